// *** rtl/psie_regs.sv ***
// Live status word, event interrupt enable and interrupt status read port.
// Assumes single-cycle read and write strobes from the management frame engine
// and line status inputs already synchronous to mclk.
`timescale 1ns/1ns
module psie_regs
	import psie_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic [4:0]  mgmt_addr,
	input  wire logic        mgmt_rd,
	input  wire logic        mgmt_wr,
	input  wire logic [15:0] mgmt_wdata,
	output logic      [15:0] mgmt_rdata,
	output logic             mgmt_rvalid,
	input  wire logic        speed_100,
	input  wire logic        tx_active,
	input  wire logic        rx_active,
	input  wire logic        collision,
	input  wire logic        link_up,
	input  wire logic        full_duplex,
	input  wire logic        neg_enabled,
	input  wire logic        neg_complete,
	input  wire logic        polarity_rev,
	input  wire logic        pause_capable,
	input  wire logic        line_error,
	output logic             mgmt_irq_out
);
	function automatic logic addr_is(input logic [4:0] a, input logic [4:0] ref_a);
		addr_is = (a == ref_a);
	endfunction

	logic [15:0]            event_interrupt_enable;
	logic [15:0]            phy_live_status_word;
	logic [15:0]            irq_status_word;
	logic [PSIE_NUM_EV-1:0] ev_set;
	logic [PSIE_NUM_EV-1:0] ev_flag;
	logic [PSIE_NUM_EV-1:0] ev_mask;
	logic                   ev_clr;
	logic                   primed;
	logic                   prev_speed;
	logic                   prev_duplex;
	logic                   prev_link;
	logic                   prev_done;
	logic                   irq_cond;
	logic                   neg_done_mask;
	logic                   speed_change_mask;
	logic                   duplex_change_mask;
	logic                   link_change_mask;
	logic                   global_irq_enable;
	logic                   test_irq_force;
	logic                   neg_done_flag;
	logic                   speed_changed_flag;
	logic                   duplex_changed_flag;
	logic                   link_changed_flag;
	logic [15:0]            next_rdata;

	assign neg_done_mask      = event_interrupt_enable[PSIE_BIT_NEGMSK];
	assign speed_change_mask  = event_interrupt_enable[PSIE_BIT_SPDMSK];
	assign duplex_change_mask = event_interrupt_enable[PSIE_BIT_DUPMSK];
	assign link_change_mask   = event_interrupt_enable[PSIE_BIT_LNKMSK];
	assign global_irq_enable  = event_interrupt_enable[PSIE_BIT_GEN];
	assign test_irq_force     = event_interrupt_enable[PSIE_BIT_TEST];

	always_comb begin
		phy_live_status_word                   = PSIE_ZERO_WORD;
		phy_live_status_word[PSIE_BIT_SPEED]   = speed_100;
		phy_live_status_word[PSIE_BIT_TX]      = tx_active;
		phy_live_status_word[PSIE_BIT_RX]      = rx_active;
		phy_live_status_word[PSIE_BIT_COL]     = collision;
		phy_live_status_word[PSIE_BIT_LINK]    = link_up;
		phy_live_status_word[PSIE_BIT_DUPLEX]  = full_duplex;
		phy_live_status_word[PSIE_BIT_NEGMODE] = neg_enabled;
		phy_live_status_word[PSIE_BIT_NEGDONE] = neg_complete;
		phy_live_status_word[PSIE_BIT_POL]     = polarity_rev;
		phy_live_status_word[PSIE_BIT_PAUSE]   = pause_capable;
		phy_live_status_word[PSIE_BIT_ERROR]   = line_error;
	end

	// Only the defined bits are stored, so reserved bits read back as zero
	// even if the controller breaks its promise to write them as zero.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			event_interrupt_enable <= PSIE_IEN_RESET;
		end else if (mgmt_wr && addr_is(mgmt_addr, PSIE_ADDR_IEN)) begin
			event_interrupt_enable <= mgmt_wdata & PSIE_IEN_WMASK;
		end
	end

	// The first cycle after reset only loads the history, so the initial line
	// state is not mistaken for a change.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			primed      <= 1'b0;
			prev_speed  <= 1'b0;
			prev_duplex <= 1'b0;
			prev_link   <= 1'b0;
			prev_done   <= 1'b0;
		end else begin
			primed      <= 1'b1;
			prev_speed  <= speed_100;
			prev_duplex <= full_duplex;
			prev_link   <= link_up;
			prev_done   <= neg_complete;
		end
	end

	always_comb begin
		ev_set    = '0;
		ev_set[3] = primed && neg_complete && !prev_done;
		ev_set[2] = primed && (speed_100 != prev_speed);
		ev_set[1] = primed && (full_duplex != prev_duplex);
		ev_set[0] = primed && (link_up != prev_link);
	end

	assign ev_clr = mgmt_rd && addr_is(mgmt_addr, PSIE_ADDR_ISTAT);

	psie_evlat u_evlat (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.ev_set  (ev_set),
		.ev_clr  (ev_clr),
		.ev_flag (ev_flag)
	);

	assign neg_done_flag       = ev_flag[3];
	assign speed_changed_flag  = ev_flag[2];
	assign duplex_changed_flag = ev_flag[1];
	assign link_changed_flag   = ev_flag[0];
	assign ev_mask = {neg_done_mask, speed_change_mask, duplex_change_mask, link_change_mask};

	assign irq_cond = (global_irq_enable && |(ev_flag & ev_mask)) || test_irq_force;

	always_comb begin
		irq_status_word                            = PSIE_ZERO_WORD;
		irq_status_word[PSIE_EV_MSB:PSIE_EV_LSB]   = ev_flag;
		irq_status_word[PSIE_BIT_PEND]             = irq_cond;
	end

	always_comb begin
		next_rdata = PSIE_ZERO_WORD;
		if (addr_is(mgmt_addr, PSIE_ADDR_LIVE)) begin
			next_rdata = phy_live_status_word;
		end else if (addr_is(mgmt_addr, PSIE_ADDR_IEN)) begin
			next_rdata = event_interrupt_enable;
		end else if (addr_is(mgmt_addr, PSIE_ADDR_ISTAT)) begin
			next_rdata = irq_status_word;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mgmt_rdata  <= PSIE_ZERO_WORD;
			mgmt_rvalid <= 1'b0;
		end else begin
			mgmt_rvalid <= mgmt_rd;
			if (mgmt_rd) begin
				mgmt_rdata <= next_rdata;
			end
		end
	end

	// Registered so the pin never glitches while flags and masks settle.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mgmt_irq_out <= 1'b0;
		end else begin
			mgmt_irq_out <= irq_cond;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_speed_bit_live: assert property (mgmt_rd && mgmt_addr == PSIE_ADDR_LIVE |=>
		mgmt_rdata[PSIE_BIT_SPEED] == $past(speed_100))
		else $error("speed bit does not follow line speed");
	a_txrx_bits_live: assert property (mgmt_rd && mgmt_addr == PSIE_ADDR_LIVE |=>
		mgmt_rdata[PSIE_BIT_TX] == $past(tx_active) && mgmt_rdata[PSIE_BIT_RX] == $past(rx_active))
		else $error("activity bits do not follow the line");
	a_line_bits_live: assert property (mgmt_rd && mgmt_addr == PSIE_ADDR_LIVE |=>
		mgmt_rdata[11:9] == $past({collision, link_up, full_duplex}))
		else $error("collision, link or duplex bit wrong");
	a_neg_bits_live: assert property (mgmt_rd && mgmt_addr == PSIE_ADDR_LIVE |=>
		mgmt_rdata[8:7] == $past({neg_enabled, neg_complete}))
		else $error("negotiation bits wrong");
	a_misc_bits_live: assert property (mgmt_rd && mgmt_addr == PSIE_ADDR_LIVE |=>
		mgmt_rdata[5:3] == $past({polarity_rev, pause_capable, line_error}))
		else $error("polarity, pause or error bit wrong");
	a_test_forces_irq: assert property (test_irq_force |=> mgmt_irq_out)
		else $error("test bit did not force the interrupt");
	a_global_gate_off: assert property (!global_irq_enable && !test_irq_force |=> !mgmt_irq_out)
		else $error("interrupt raised while globally disabled");
	a_masked_events: assert property (global_irq_enable && !test_irq_force
		&& (ev_flag & ev_mask) == '0 |=> !mgmt_irq_out)
		else $error("masked event raised the interrupt");
	a_neg_done_irq: assert property (global_irq_enable && neg_done_flag && neg_done_mask
		|=> mgmt_irq_out)
		else $error("unmasked negotiation event did not interrupt");
	// A clearing read right after the change may legally drop the flag a cycle later.
	a_link_change_latch: assert property (primed && $changed(link_up) |=>
		link_changed_flag ##1 (link_changed_flag || $past(ev_clr)))
		else $error("link change not latched");
	a_speed_dup_irq: assert property (global_irq_enable && (
		(speed_changed_flag && speed_change_mask) || (duplex_changed_flag && duplex_change_mask))
		|=> mgmt_irq_out)
		else $error("unmasked speed or duplex event did not interrupt");
	a_link_irq: assert property (global_irq_enable && link_changed_flag && link_change_mask
		|=> mgmt_irq_out)
		else $error("unmasked link event did not interrupt");
	a_read_clears: assert property (ev_clr && ev_set == '0 |=> ev_flag == '0)
		else $error("status read did not clear flags");
	a_pend_bit_read: assert property (ev_clr |=> mgmt_rdata[PSIE_BIT_PEND] == $past(irq_cond))
		else $error("pending bit wrong");
	a_reserved_zero: assert property (event_interrupt_enable == (event_interrupt_enable & PSIE_IEN_WMASK))
		else $error("reserved enable bit stored");

	c_link_irq:   cover property (link_changed_flag && link_change_mask && global_irq_enable ##1 mgmt_irq_out);
	c_read_clear: cover property (ev_clr && ev_flag != '0 ##1 ev_flag == '0);
	c_set_on_clr: cover property (ev_clr && ev_set != '0);
	c_test_irq:   cover property (test_irq_force && !global_irq_enable ##1 mgmt_irq_out);
	c_neg_irq:    cover property (neg_done_flag && neg_done_mask && global_irq_enable ##1 mgmt_irq_out);
endmodule

// *** rtl/psie_pkg.sv ***
// Constants for the live status word and the event interrupt enable register.
// Assumes an MDIO frame engine outside that presents decoded register strobes.
package psie_pkg;
	localparam logic [4:0]  PSIE_ADDR_LIVE   = 5'h11;
	localparam logic [4:0]  PSIE_ADDR_IEN    = 5'h12;
	localparam logic [4:0]  PSIE_ADDR_ISTAT  = 5'h13;
	localparam logic [15:0] PSIE_ZERO_WORD   = 16'h0000;
	localparam logic [15:0] PSIE_IEN_RESET   = 16'h0000;
	localparam logic [15:0] PSIE_IEN_WMASK   = 16'h00f3;
	localparam int          PSIE_BIT_SPEED   = 14;
	localparam int          PSIE_BIT_TX      = 13;
	localparam int          PSIE_BIT_RX      = 12;
	localparam int          PSIE_BIT_COL     = 11;
	localparam int          PSIE_BIT_LINK    = 10;
	localparam int          PSIE_BIT_DUPLEX  = 9;
	localparam int          PSIE_BIT_NEGMODE = 8;
	localparam int          PSIE_BIT_NEGDONE = 7;
	localparam int          PSIE_BIT_POL     = 5;
	localparam int          PSIE_BIT_PAUSE   = 4;
	localparam int          PSIE_BIT_ERROR   = 3;
	localparam int          PSIE_BIT_NEGMSK  = 7;
	localparam int          PSIE_BIT_SPDMSK  = 6;
	localparam int          PSIE_BIT_DUPMSK  = 5;
	localparam int          PSIE_BIT_LNKMSK  = 4;
	localparam int          PSIE_BIT_GEN     = 1;
	localparam int          PSIE_BIT_TEST    = 0;
	localparam int          PSIE_EV_LSB      = 4;
	localparam int          PSIE_EV_MSB      = 7;
	localparam int          PSIE_BIT_PEND    = 2;
	localparam int          PSIE_NUM_EV      = 4;
endpackage

// *** rtl/psie_evlat.sv ***
// Sticky event flags that clear on a read strobe.
// Assumes set and clear are one-cycle pulses on mclk.
`timescale 1ns/1ns
module psie_evlat
	import psie_pkg::*;
(
	input  wire logic                   mclk,
	input  wire logic                   rst_b,
	input  wire logic [PSIE_NUM_EV-1:0] ev_set,
	input  wire logic                   ev_clr,
	output logic      [PSIE_NUM_EV-1:0] ev_flag
);
	// A set in the clearing cycle survives, so no event slips between reads.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ev_flag <= '0;
		end else begin
			ev_flag <= (ev_flag & ~{PSIE_NUM_EV{ev_clr}}) | ev_set;
		end
	end
endmodule

// *** bench/psie_mgmt_host.sv ***
// Management controller model that issues register strobes to the status block.
// Assumes one mclk domain and the decoded strobe port of the register block.
`timescale 1ns/1ns
module psie_mgmt_host
	import psie_pkg::*;
(
	input  wire logic        mclk,
	output logic      [4:0]  mgmt_addr,
	output logic             mgmt_rd,
	output logic             mgmt_wr,
	output logic      [15:0] mgmt_wdata,
	input  wire logic [15:0] mgmt_rdata,
	input  wire logic        mgmt_rvalid
);
	initial begin
		mgmt_addr = 5'h00;
		mgmt_rd = 1'b0;
		mgmt_wr = 1'b0;
		mgmt_wdata = 16'h0000;
	end
	// Released lines show inverted values so a stale sample cannot pass as valid.
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		#1;
		mgmt_addr = a;
		mgmt_wdata = (a == PSIE_ADDR_IEN) ? (d & PSIE_IEN_WMASK) : d;
		mgmt_wr = 1'b1;
		@(posedge mclk);
		#1;
		mgmt_wr = 1'b0;
		mgmt_addr = ~a;
		mgmt_wdata = ~mgmt_wdata;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
		@(posedge mclk);
		#1;
		mgmt_addr = a;
		mgmt_rd = 1'b1;
		@(posedge mclk);
		#1;
		mgmt_rd = 1'b0;
		mgmt_addr = ~a;
		d = mgmt_rdata;
		v = mgmt_rvalid;
	endtask
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the live status word and event interrupt enable block.
// Assumes the controller model drives the register port and the bench drives line status.
`timescale 1ns/1ns
module tb_top;
	import psie_pkg::*;
	logic        mclk;
	logic        rst_b;
	logic [10:0] lv;
	logic [4:0]  mgmt_addr;
	logic        mgmt_rd;
	logic        mgmt_wr;
	logic [15:0] mgmt_wdata;
	logic [15:0] mgmt_rdata;
	logic        mgmt_rvalid;
	logic        mgmt_irq_out;
	logic [15:0] d;
	logic        v;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          ev_pos [4] = '{6, 5, 10, 3};
	psie_mgmt_host u_host (.mclk(mclk), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd),
		.mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.mgmt_rvalid(mgmt_rvalid));
	psie_regs u_dut (.mclk(mclk), .rst_b(rst_b), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd),
		.mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.mgmt_rvalid(mgmt_rvalid), .speed_100(lv[10]), .tx_active(lv[9]),
		.rx_active(lv[8]), .collision(lv[7]), .link_up(lv[6]), .full_duplex(lv[5]),
		.neg_enabled(lv[4]), .neg_complete(lv[3]), .polarity_rev(lv[2]),
		.pause_capable(lv[1]), .line_error(lv[0]), .mgmt_irq_out(mgmt_irq_out));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic rchk(input logic [4:0] a, input logic [15:0] exp, input string msg);
		u_host.rd(a, d, v);
		chk({15'h0000, v}, 16'h0001, "read answer");
		chk(d, exp, msg);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	function automatic logic [15:0] live_exp(input logic [10:0] l);
		return {1'b0, l[10:3], 1'b0, l[2:0], 3'b000};
	endfunction
	// A hang costs a mismatch rather than a silent stall.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: run did not finish", $time);
			report_and_stop();
		end
	end
	initial begin
		lv = 11'h000;
		rst_b = 1'b0;
		wt(5);
		rst_b = 1'b1;
		rchk(PSIE_ADDR_IEN, PSIE_IEN_RESET, "enable reset");
		rchk(PSIE_ADDR_LIVE, PSIE_ZERO_WORD, "live reset");
		$display("test reset done");
		for (int i = 0; i < 11; i++) begin
			lv = 11'h001 << i;
			rchk(PSIE_ADDR_LIVE, live_exp(lv), "live word");
		end
		lv = 11'h000;
		u_host.wr(PSIE_ADDR_LIVE, 16'hffff);
		rchk(PSIE_ADDR_LIVE, PSIE_ZERO_WORD, "live write ignored");
		rchk(5'h1f, PSIE_ZERO_WORD, "unmapped read");
		u_host.rd(PSIE_ADDR_ISTAT, d, v);
		$display("test live word done");
		u_host.wr(PSIE_ADDR_IEN, 16'hffff);
		rchk(PSIE_ADDR_IEN, 16'h00f3, "enable readback");
		wt(1);
		chk({15'h0000, mgmt_irq_out}, 16'h0001, "forced irq");
		rchk(PSIE_ADDR_ISTAT, 16'h0004, "forced pending");
		u_host.wr(PSIE_ADDR_IEN, 16'h00f2);
		wt(2);
		chk({15'h0000, mgmt_irq_out}, 16'h0000, "force released");
		$display("test force done");
		for (int k = 0; k < 4; k++) begin
			u_host.wr(PSIE_ADDR_IEN, 16'h0002);
			lv[ev_pos[k]] = 1'b1;
			wt(3);
			chk({15'h0000, mgmt_irq_out}, 16'h0000, "masked event");
			rchk(PSIE_ADDR_ISTAT, 16'h0010 << k, "latched flag");
			lv[ev_pos[k]] = 1'b0;
			wt(2);
			u_host.rd(PSIE_ADDR_ISTAT, d, v);
			u_host.wr(PSIE_ADDR_IEN, (16'h0010 << k) | 16'h0002);
			lv[ev_pos[k]] = 1'b1;
			wt(3);
			chk({15'h0000, mgmt_irq_out}, 16'h0001, "enabled event");
			rchk(PSIE_ADDR_ISTAT, (16'h0010 << k) | 16'h0004, "flag pending");
			wt(2);
			chk({15'h0000, mgmt_irq_out}, 16'h0000, "cleared by read");
			lv = 11'h000;
			wt(2);
			u_host.rd(PSIE_ADDR_ISTAT, d, v);
		end
		$display("test events done");
		u_host.wr(PSIE_ADDR_IEN, 16'h00f0);
		lv[6] = 1'b1;
		wt(3);
		chk({15'h0000, mgmt_irq_out}, 16'h0000, "global off");
		rchk(PSIE_ADDR_ISTAT, 16'h0010, "flag without pending");
		$display("test global enable done");
		// A change that lands on the clearing read must survive it.
		fork
			u_host.rd(PSIE_ADDR_ISTAT, d, v);
			begin
				@(posedge mclk);
				#1;
				lv[6] = 1'b0;
			end
		join
		chk(d, PSIE_ZERO_WORD, "pre-clear data");
		rchk(PSIE_ADDR_ISTAT, 16'h0010, "set beats clear");
		$display("test set during clear done");
		u_host.wr(PSIE_ADDR_IEN, 16'h0001);
		wt(2);
		chk({15'h0000, mgmt_irq_out}, 16'h0001, "forced before reset");
		rst_b = 1'b0;
		wt(2);
		chk({15'h0000, mgmt_irq_out}, 16'h0000, "irq in reset");
		rst_b = 1'b1;
		rchk(PSIE_ADDR_IEN, PSIE_IEN_RESET, "enable after reset");
		rchk(PSIE_ADDR_ISTAT, PSIE_ZERO_WORD, "flags after reset");
		chk({15'h0000, mgmt_irq_out}, 16'h0000, "irq after reset");
		$display("test mid reset done");
		report_and_stop();
	end
endmodule
